// File: ui2c_defs.svh
// Register offsets, field positions, reset values and frame bit count
`ifndef UI2C_DEFS_SVH
`define UI2C_DEFS_SVH
// Register indices (byte address = index)
`define UI2C_A_RXBUF 4'h0
`define UI2C_A_BRG 4'h1
`define UI2C_A_MODE 4'h2
`define UI2C_A_CTL0 4'h3
`define UI2C_A_CTL1 4'h4
`define UI2C_A_SMR 4'h5
`define UI2C_A_SMR2 4'h6
`define UI2C_A_SMR3 4'h7
`define UI2C_A_SMR4 4'h8
`define UI2C_A_TXBUF 4'h9
`define UI2C_A_IRQ 4'ha
`define UI2C_A_ISEL 4'hb
`define UI2C_A_SHARED_SERIAL_CONTROL 4'hc
// Mode field values
`define UI2C_SMD_I2C 3'h2
`define UI2C_SMD_OFF 3'h0
// Mode register bits
`define UI2C_MR_CLOCK_SOURCE_DIRECTION 3
// Control 0 bits
`define UI2C_C0_OER 7
// Control 1 bits
`define UI2C_C1_TE 0
`define UI2C_C1_TI 1
`define UI2C_C1_RE 2
`define UI2C_C1_RI 3
// Special mode bits
`define UI2C_SMR_TWO_WIRE_MODE_SELECT 0
`define UI2C_SMR_ABC 1
`define UI2C_SMR_BBS 2
`define UI2C_SMR2_ACK_INTERRUPT_MODE_SELECT 0
`define UI2C_SMR2_CSC 1
`define UI2C_SMR2_SWC 2
`define UI2C_SMR2_ALS 3
`define UI2C_SMR2_START_DETECT_REINIT 4
`define UI2C_SMR2_SWC2 5
`define UI2C_SMR2_DATA_LINE_DISABLE 6
`define UI2C_SMR3_CLOCK_DELAY_SELECT 1
`define UI2C_SMR3_DL 5
`define UI2C_SMR4_STA 0
`define UI2C_SMR4_RSTA 1
`define UI2C_SMR4_STP 2
`define UI2C_SMR4_SEL 3
`define UI2C_SMR4_ACK_VALUE_SELECT 4
`define UI2C_SMR4_ACK_OUTPUT_ENABLE 5
`define UI2C_SMR4_SCLHI 6
`define UI2C_SMR4_SWC9 7
// Interrupt flag bits
`define UI2C_IRQ_COND 0
`define UI2C_IRQ_TX 1
`define UI2C_IRQ_RX 2
// Reset values
`define UI2C_RST_BYTE 8'h00
`define UI2C_RST_SMR4 8'h00
// Bit count per frame, ack bit included
`define UI2C_BITS 4'h9
`endif

// File: ui2c_pkg.sv
// Types shared by the two-wire serial engine
package ui2c_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ui2c_req_t;
	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} ui2c_pins_t;
	typedef enum logic [2:0] {
		UI2C_IDLE = 3'b000,
		UI2C_CA = 3'b001,
		UI2C_CB = 3'b011,
		UI2C_CC = 3'b010,
		UI2C_CD = 3'b110
	} ui2c_cond_t;
endpackage

// File: ui2c_engine.sv
// Two-wire serial mode engine with register port
//
// Function
// RQ1 - Software selects two-wire mode: mode field 010b and mode select bit one.
// RQ2 - Data falling while clock high raises the start-detected interrupt.
// RQ3 - Data rising while clock high raises the stop-detected interrupt.
// RQ4 - Start and stop share one flag; busy flag tells them apart.
// RQ5 - Writing a request bit generates start, restart or stop.
// RQ6 - Software sets request bit first, then condition output select.
// RQ7 - Select zero: pins carry only transfer clock and data.
// RQ8 - Select one: pins output condition; interrupt on finish, not detection.
// RQ9 - Receive buffer load at bit 9 rising or falling, per ack mode.
// RQ10 - Ack mode one: transmit interrupt at bit 9 rise or next fall.
// RQ11 - Ack mode zero: NACK or ACK interrupt at bit 9 rising edge.
// RQ12 - Second load with clock delay places bits 1..8 into buffer 7..0.
// RQ13 - First load: buffer 6..0 gets bits 7..1, buffer 8 gets bit 8.
// RQ14 - Data output is delayed from the clock by a three-bit field.
// RQ15 - Software loads initial data level while mode field is 000b.
// RQ16 - Clock idles high without clock delay, low with it.
// RQ17 - Ninth-bit hold pins clock low from falling edge of bit 9.
// RQ18 - Master with data stop enabled releases data on arbitration loss.
// RQ19 - Data line disable forces data output off.
// RQ20 - Slave start detect with reinit enabled resets shift logic.
// RQ21 - Master clock sync follows the observed clock line.
// RQ22 - Update timing bit selects bitwise or bytewise arbitration flag.
// RQ23 - Ack output enable drives the selected ack value in ack slot.
// RQ24 - Software clears interrupt flags after changing mode bits.
// RQ25 - Master software picks divider source and value; slave ignores it.
// RQ26 - Master clock rate is source over 2 times divider plus one.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`include "ui2c_defs.svh"

module ui2c_engine (
	input wire logic clk,
	input wire logic rst,
	input wire ui2c_pkg::ui2c_req_t req,
	output logic [15:0] rdata,
	input wire logic scl_i,
	input wire logic sda_i,
	output ui2c_pkg::ui2c_pins_t pins,
	output logic irq_cond,
	output logic irq_tx,
	output logic irq_rx
);
	import ui2c_pkg::*;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_m_q <= scl_i;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= sda_i;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
		end
	end
	wire scl_rise = scl_s_q & ~scl_p_q;
	wire scl_fall = ~scl_s_q & scl_p_q;
	// Start and stop detection
	// RQ2 start detect
	wire start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	// RQ3 stop detect
	wire stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] brg_q, mr_q, c0_q, c1_q, smr_q, smr2_q, smr3_q, smr4_q, tb_q, isel_q, shared_serial_control_q;
	logic [2:0] irq_q;
	logic [8:0] rb_q;
	logic abt_q, oer_q, bbs_q;
	wire wr = req.wr;
	// RQ1 mode decode
	wire i2c_on = (mr_q[2:0] == `UI2C_SMD_I2C) & smr_q[`UI2C_SMR_TWO_WIRE_MODE_SELECT];
	wire master = ~mr_q[`UI2C_MR_CLOCK_SOURCE_DIRECTION];
	wire ackm = smr2_q[`UI2C_SMR2_ACK_INTERRUPT_MODE_SELECT];
	wire clock_delay_select = smr3_q[`UI2C_SMR3_CLOCK_DELAY_SELECT];
	wire sel = smr4_q[`UI2C_SMR4_SEL];
	wire w_smr2 = wr & (req.addr == `UI2C_A_SMR2);
	wire w_smr4 = wr & (req.addr == `UI2C_A_SMR4);
	wire w_irq = wr & (req.addr == `UI2C_A_IRQ);
	wire w_rb = wr & (req.addr == `UI2C_A_RXBUF);
	wire w_tb = wr & (req.addr == `UI2C_A_TXBUF);

	// ----------------------------------------
	// Bit rate divider
	// ----------------------------------------
	// RQ26 half period is brg+1 source ticks
	logic [4:0] pre_q;
	logic [7:0] div_q;
	logic tick_q;
	wire [4:0] pre_max = (c0_q[1:0] == 2'h0) ? 5'h00 : (c0_q[1:0] == 2'h1) ? 5'h01 :
		(c0_q[1:0] == 2'h2) ? 5'h07 : 5'h1f;
	wire src_tick = (pre_q == pre_max);
	wire restart_div;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pre_q <= 5'h00;
			div_q <= 8'h00;
			tick_q <= 1'b0;
		end else begin
			pre_q <= src_tick ? 5'h00 : pre_q + 5'h01;
			tick_q <= 1'b0;
			if (restart_div) begin
				div_q <= brg_q;
			end else if (src_tick) begin
				div_q <= (div_q == 8'h00) ? brg_q : div_q - 8'h01;
				tick_q <= (div_q == 8'h00);
			end
		end
	end

	// ----------------------------------------
	// Transfer clock and shifter
	// ----------------------------------------
	logic iscl_q, active_q, hold_q, hold9_q, sda_out_q, ninth_q, ackp_q;
	logic [3:0] bit_q;
	logic [7:0] tsh_q;
	logic [8:0] rsh_q;
	logic [2:0] cst_q;
	ui2c_cond_t cond_q;
	wire go = i2c_on & c1_q[`UI2C_C1_TE] & ~c1_q[`UI2C_C1_TI];
	// RQ21 sync with bus clock
	wire clock_sync_enable = smr2_q[`UI2C_SMR2_CSC] & master;
	assign restart_div = clock_sync_enable & scl_fall & iscl_q;
	wire stalled = clock_sync_enable & iscl_q & ~scl_s_q;
	wire int_tick = tick_q & ~stalled & master & active_q & ~sel;
	// Effective transfer clock edges
	wire bclk_rise = master ? (int_tick & ~iscl_q) : scl_rise;
	wire bclk_fall = master ? ((int_tick & iscl_q) | restart_div) : scl_fall;
	wire at9 = (bit_q == `UI2C_BITS - 4'h1);
	wire bit9_rise = active_q & bclk_rise & at9;
	wire bit9_fall = active_q & bclk_fall & ninth_q;
	wire start_detect_reinit = smr2_q[`UI2C_SMR2_START_DETECT_REINIT] & ~master;
	// RQ20 reinit on start
	wire reinit = start_detect_reinit & start_det & i2c_on;
	wire arb_miss = active_q & bclk_rise & ~at9 & sda_out_q & ~sda_s_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			iscl_q <= 1'b1;
			active_q <= 1'b0;
			bit_q <= 4'h0;
			tsh_q <= 8'hff;
			rsh_q <= 9'h000;
			ninth_q <= 1'b0;
			ackp_q <= 1'b0;
		end else begin
			if (reinit) begin
				active_q <= 1'b1;
				bit_q <= 4'h0;
				tsh_q <= tb_q;
				rsh_q <= 9'h000;
				ackp_q <= 1'b0;
			end else if (!active_q && go) begin
				active_q <= 1'b1;
				bit_q <= 4'h0;
				tsh_q <= tb_q;
				ackp_q <= 1'b0;
				// RQ16 idle level by delay
				iscl_q <= ~clock_delay_select;
			end else if (active_q) begin
				if (int_tick)
					iscl_q <= ~iscl_q;
				if (bclk_rise) begin
					rsh_q <= {rsh_q[7:0], sda_s_q};
					if (at9)
						ninth_q <= 1'b1;
					else
						bit_q <= bit_q + 4'h1;
				end
				if (bclk_fall && !ninth_q && bit_q != 4'h0)
					tsh_q <= {tsh_q[6:0], 1'b1};
				// Ack slot opens once bit 8 is out, so the ack stands before bit 9 rises
				if (bclk_fall && !ninth_q && at9)
					ackp_q <= 1'b1;
				if (bit9_fall) begin
					ninth_q <= 1'b0;
					ackp_q <= 1'b0;
					active_q <= 1'b0;
					bit_q <= 4'h0;
					iscl_q <= ~clock_delay_select;
				end
			end
			if (!i2c_on)
				active_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Condition generator
	// ----------------------------------------
	// RQ5 request to condition
	wire any_req = |smr4_q[2:0];
	wire cond_step = tick_q & sel & master;
	wire cond_done = cond_step & (cond_q == UI2C_CD);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cond_q <= UI2C_IDLE;
			cst_q <= 3'h0;
		end else if (cond_step) begin
			unique case (cond_q)
				UI2C_IDLE: if (any_req) begin
					cond_q <= UI2C_CA;
					cst_q <= smr4_q[2:0];
				end
				UI2C_CA: cond_q <= UI2C_CB;
				UI2C_CB: cond_q <= UI2C_CC;
				UI2C_CC: cond_q <= UI2C_CD;
				UI2C_CD: cond_q <= UI2C_IDLE;
			endcase
		end
	end
	// Condition waveforms: both lines go low after start or restart and stay high after stop, else idle would make a false stop
	logic c_scl, c_sda;
	wire is_stop = cst_q[`UI2C_SMR4_STP];
	wire no_cond = (cst_q == 3'h0);
	assign c_scl = (cond_q == UI2C_IDLE) ? (no_cond ? iscl_q : is_stop) :
		((cond_q != UI2C_CA) | cst_q[`UI2C_SMR4_STA]);
	assign c_sda = (cond_q == UI2C_IDLE) ? (no_cond | is_stop) :
		(cond_q == UI2C_CA || cond_q == UI2C_CB) ? ~is_stop : is_stop;

	// ----------------------------------------
	// Data output delay
	// ----------------------------------------
	// RQ14 delayed data output
	logic [7:0] dly_q;
	logic [2:0] dl_q;
	wire [2:0] dl = smr3_q[7:5];
	wire ack_slot = ninth_q | ackp_q;
	// RQ23 ack value drive
	wire raw_sda = (ack_slot & smr4_q[`UI2C_SMR4_ACK_OUTPUT_ENABLE]) ? smr4_q[`UI2C_SMR4_ACK_VALUE_SELECT] :
		(ack_slot ? 1'b1 : tsh_q[7]);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dly_q <= 8'hff;
			sda_out_q <= 1'b1;
			dl_q <= 3'h0;
		end else begin
			dl_q <= dl;
			if (src_tick)
				dly_q <= {dly_q[6:0], raw_sda};
			sda_out_q <= (dl_q == 3'h0) ? raw_sda : dly_q[dl_q];
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	// RQ17 clock hold after bit 9
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hold_q <= 1'b0;
			hold9_q <= 1'b0;
		end else begin
			if (bit9_fall && smr2_q[`UI2C_SMR2_SWC])
				hold_q <= 1'b1;
			else if (w_smr2 && !req.wdata[`UI2C_SMR2_SWC])
				hold_q <= 1'b0;
			if (bit9_fall && clock_delay_select && smr4_q[`UI2C_SMR4_SWC9])
				hold9_q <= 1'b1;
			else if (!smr4_q[`UI2C_SMR4_SWC9])
				hold9_q <= 1'b0;
		end
	end
	// RQ7 RQ8 pin source select
	wire scl_lvl = (sel ? c_scl : iscl_q) & ~hold_q & ~hold9_q & ~smr2_q[`UI2C_SMR2_SWC2];
	// RQ18 RQ19 data release
	wire sda_kill = smr2_q[`UI2C_SMR2_DATA_LINE_DISABLE] | (master & smr2_q[`UI2C_SMR2_ALS] & abt_q);
	wire sda_lvl = sel ? c_sda : sda_out_q;
	assign pins.scl_o = 1'b0;
	assign pins.scl_oe = i2c_on & ~scl_lvl & (master | hold_q | hold9_q);
	assign pins.sda_o = 1'b0;
	// RQ15 initial level from software
	assign pins.sda_oe = (i2c_on | (mr_q[2:0] == `UI2C_SMD_OFF)) & ~sda_lvl & ~sda_kill;

	// ----------------------------------------
	// Receive buffer, arbitration, flags
	// ----------------------------------------
	wire tx_ev = ackm & (clock_delay_select ? bit9_fall : bit9_rise);
	wire rx_ev = ackm & bit9_fall;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rb_q <= 9'h000;
			abt_q <= 1'b0;
			oer_q <= 1'b0;
			bbs_q <= 1'b0;
			irq_q <= 3'h0;
		end else begin
			// RQ9 RQ11 RQ12 buffer load
			if (bit9_rise && (!ackm || clock_delay_select))
				rb_q <= {sda_s_q, rsh_q[7:0]};
			// RQ13 first load layout
			if (ackm && bit9_fall)
				rb_q <= {rsh_q[1], 1'b0, rsh_q[8:2]};
			// RQ22 arbitration update timing
			if (w_rb)
				abt_q <= 1'b0;
			if (arb_miss)
				abt_q <= 1'b1;
			else if (!smr_q[`UI2C_SMR_ABC] && active_q && bclk_rise && !at9)
				abt_q <= 1'b0;
			if (bit9_rise && c1_q[`UI2C_C1_RI])
				oer_q <= 1'b1;
			else if (w_rb)
				oer_q <= 1'b0;
			// RQ4 busy flag
			if (start_det)
				bbs_q <= 1'b1;
			else if (stop_det)
				bbs_q <= 1'b0;
			// Set wins over software clear
			if (w_irq)
				irq_q <= irq_q & ~req.wdata[2:0];
			// RQ8 condition flag source
			if ((sel ? cond_done : (start_det | stop_det)) && i2c_on)
				irq_q[`UI2C_IRQ_COND] <= 1'b1;
			// RQ10 RQ11 ack and tx flags
			if ((tx_ev || (!ackm && bit9_rise && sda_s_q)) && i2c_on)
				irq_q[`UI2C_IRQ_TX] <= 1'b1;
			if ((rx_ev || (!ackm && bit9_rise && !sda_s_q)) && i2c_on)
				irq_q[`UI2C_IRQ_RX] <= 1'b1;
		end
	end

	// ----------------------------------------
	// Register writes and read port
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{brg_q, mr_q, c0_q, smr_q, smr2_q, smr3_q, tb_q, isel_q, shared_serial_control_q} <= {9{`UI2C_RST_BYTE}};
			c1_q <= 8'h02;
			smr4_q <= `UI2C_RST_SMR4;
			rdata <= 16'h0000;
		end else begin
			if (wr) begin
				unique case (req.addr)
					`UI2C_A_BRG: brg_q <= req.wdata;
					`UI2C_A_MODE: mr_q <= req.wdata;
					`UI2C_A_CTL0: c0_q <= req.wdata;
					`UI2C_A_CTL1: c1_q <= {req.wdata[7:4], c1_q[3], req.wdata[2], c1_q[1], req.wdata[0]};
					`UI2C_A_SMR: smr_q <= req.wdata;
					`UI2C_A_SMR2: smr2_q <= req.wdata;
					`UI2C_A_SMR3: smr3_q <= req.wdata;
					`UI2C_A_SMR4: smr4_q <= req.wdata;
					`UI2C_A_ISEL: isel_q <= req.wdata;
					`UI2C_A_SHARED_SERIAL_CONTROL: shared_serial_control_q <= req.wdata;
					default: ;
				endcase
			end
			if (w_tb)
				c1_q[`UI2C_C1_TI] <= 1'b0;
			if (w_tb)
				tb_q <= req.wdata;
			if (w_rb)
				c1_q[`UI2C_C1_RI] <= 1'b0;
			if (!active_q && go)
				c1_q[`UI2C_C1_TI] <= 1'b1;
			if (bit9_rise)
				c1_q[`UI2C_C1_RI] <= 1'b1;
			// RQ20 wait enabled by reinit
			if (reinit)
				smr2_q[`UI2C_SMR2_SWC] <= 1'b1;
			// Requests self-clear once the condition is out
			if (cond_done && !w_smr4)
				smr4_q[2:0] <= 3'h0;
			rdata <= 16'h0000;
			if (req.rd) begin
				unique case (req.addr)
					`UI2C_A_RXBUF: rdata <= {oer_q, abt_q, 5'h00, rb_q};
					`UI2C_A_BRG: rdata <= {8'h00, brg_q};
					`UI2C_A_MODE: rdata <= {8'h00, mr_q};
					`UI2C_A_CTL0: rdata <= {8'h00, c0_q};
					`UI2C_A_CTL1: rdata <= {8'h00, c1_q};
					`UI2C_A_SMR: rdata <= {8'h00, smr_q[7:3], bbs_q, smr_q[1:0]};
					`UI2C_A_SMR2: rdata <= {8'h00, smr2_q};
					`UI2C_A_SMR3: rdata <= {8'h00, smr3_q};
					`UI2C_A_SMR4: rdata <= {8'h00, smr4_q};
					`UI2C_A_TXBUF: rdata <= {8'h00, tb_q};
					`UI2C_A_IRQ: rdata <= {13'h0000, irq_q};
					`UI2C_A_ISEL: rdata <= {8'h00, isel_q};
					`UI2C_A_SHARED_SERIAL_CONTROL: rdata <= {8'h00, shared_serial_control_q};
					default: rdata <= 16'h0000;
				endcase
			end
		end
	end
	assign irq_cond = irq_q[`UI2C_IRQ_COND];
	assign irq_tx = irq_q[`UI2C_IRQ_TX];
	assign irq_rx = irq_q[`UI2C_IRQ_RX];

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	start_flag_a: assert property (@(posedge clk) disable iff (rst) // RQ2
		(start_det && i2c_on && !sel) |=> irq_cond) else $error("start not flagged");
	busy_track_a: assert property (@(posedge clk) disable iff (rst) // RQ4
		start_det |=> bbs_q) else $error("busy flag not set");
	stop_idle_a: assert property (@(posedge clk) disable iff (rst) // RQ3
		(stop_det && !start_det) |=> !bbs_q) else $error("busy flag not cleared");
	sda_off_a: assert property (@(posedge clk) disable iff (rst) // RQ19
		smr2_q[`UI2C_SMR2_DATA_LINE_DISABLE] |-> !pins.sda_oe) else $error("data driven while disabled");
	arb_stop_a: assert property (@(posedge clk) disable iff (rst) // RQ18
		(master && smr2_q[`UI2C_SMR2_ALS] && abt_q) |-> !pins.sda_oe) else $error("data driven after loss");
	hold_low_a: assert property (@(posedge clk) disable iff (rst) // RQ17
		(bit9_fall && smr2_q[`UI2C_SMR2_SWC] && i2c_on) |=> pins.scl_oe) else $error("clock not held");
	nack_flag_a: assert property (@(posedge clk) disable iff (rst) // RQ11
		(i2c_on && !ackm && bit9_rise && sda_s_q) |=> irq_tx) else $error("nack missed");
	cond_done_a: assert property (@(posedge clk) disable iff (rst) // RQ8
		(cond_done && i2c_on) |=> irq_cond ##1 (smr4_q[2:0] == 3'h0 || $past(w_smr4))) else $error("condition end");
endmodule // ui2c_engine

// File: ui2c_bus_model.sv
// Behavioural far-side bus master sharing the two open-drain lines with the engine
`timescale 1ns/1ps

module ui2c_bus_model (
	input wire logic clk,
	input wire logic scl,
	input wire logic sda,
	output logic scl_low,
	output logic sda_low,
	output logic in_ack,
	output logic ack_seen,
	output int n_start,
	output int n_stop
);
	localparam int HALF = 10;

	initial begin
		scl_low = 1'h0;
		sda_low = 1'h0;
		in_ack = 1'h0;
		ack_seen = 1'h0;
		n_start = 0;
		n_stop = 0;
	end

	// ----------------------------------------
	// Bus monitor
	// ----------------------------------------
	// Time zero skipped: lines leave unknown there
	always @(negedge sda) begin
		if (scl === 1'h1 && $time > 0)
			n_start = n_start + 1;
	end
	always @(posedge sda) begin
		if (scl === 1'h1 && $time > 0)
			n_stop = n_stop + 1;
	end

	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	task automatic wait_half();
		repeat (HALF) @(posedge clk);
	endtask

	// Slave may stretch, but the wait is bounded
	task automatic release_scl();
		scl_low <= 1'h0;
		@(posedge clk);
		for (int j = 0; j < 200 && scl !== 1'h1; j++)
			@(posedge clk);
	endtask

	task automatic start_c();
		sda_low <= 1'h1;
		wait_half();
		scl_low <= 1'h1;
		wait_half();
	endtask

	task automatic stop_c();
		sda_low <= 1'h1;
		wait_half();
		release_scl();
		wait_half();
		sda_low <= 1'h0;
		wait_half();
	endtask

	// Eight data bits then the ack slot; clock left low afterwards
	task automatic send_byte(input logic [7:0] b, input logic ack_low);
		logic [8:0] frame;
		frame = {b, ~ack_low};
		for (int i = 8; i >= 0; i--) begin
			scl_low <= 1'h1;
			wait_half();
			sda_low <= ~frame[i];
			wait_half();
			release_scl();
			in_ack <= (i == 0);
			wait_half();
			if (i == 0)
				ack_seen <= sda;
			in_ack <= 1'h0;
		end
		scl_low <= 1'h1;
		wait_half();
		sda_low <= 1'h0;
	endtask
endmodule // ui2c_bus_model

// File: ui2c_engine_test.sv
// Self-checking bench for the two-wire serial engine
`timescale 1ns/1ps
`include "ui2c_defs.svh"

module ui2c_engine_test;
	import ui2c_pkg::*;
	logic clk;
	logic rst;
	ui2c_req_t req;
	logic [15:0] rdata;
	ui2c_pins_t pins;
	logic irq_cond;
	logic irq_tx;
	logic irq_rx;
	logic scl_low;
	logic sda_low;
	logic in_ack;
	logic ack_seen;
	int n_start;
	int n_stop;
	wire logic scl_w;
	wire logic sda_w;
	int miscompares = 0;
	int check_count = 0;
	int exp_start = 0;
	int exp_stop = 0;
	integer seed = 32'h947fd986;
	logic [15:0] got;
	logic [7:0] b;
	logic m2;
	logic [7:0] smr2_tab [5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h40};
	logic [7:0] smr4_tab [5] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h20};
	logic mlow_tab [5] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0};
	logic nine_tab [5] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h1};
	logic [7:0] cond_tab [3] = '{8'h09, 8'h0a, 8'h0c};

	// Open-drain lines with pull-ups
	assign scl_w = ~(pins.scl_oe | scl_low);
	assign sda_w = ~(pins.sda_oe | sda_low);

	ui2c_engine DUT (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .scl_i(scl_w), .sda_i(sda_w),
		.pins(pins), .irq_cond(irq_cond), .irq_tx(irq_tx), .irq_rx(irq_rx));
	ui2c_bus_model PARTNER (.clk(clk), .scl(scl_w), .sda(sda_w), .scl_low(scl_low), .sda_low(sda_low),
		.in_ack(in_ack), .ack_seen(ack_seen), .n_start(n_start), .n_stop(n_stop));

	always #50 clk = ~clk;

	// ----------------------------------------
	// Model and helpers
	// ----------------------------------------
	function automatic logic [15:0] rx_model(input logic mode2, input logic nine, input logic [7:0] d);
		return mode2 ? {7'h00, d[0], 1'h0, d[7:1]} : {7'h00, nine, d};
	endfunction

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'h1;
		@(posedge clk);
		req.wr <= 1'h0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] q);
		@(posedge clk);
		req.addr <= a;
		req.rd <= 1'h1;
		@(posedge clk);
		req.rd <= 1'h0;
		#1;
		q = rdata;
	endtask

	task automatic wait_cond();
		for (int j = 0; j < 400 && irq_cond !== 1'h1; j++)
			tick(1);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Hang guard, well past the few thousand cycles the tests need
	initial begin
		repeat (30000) @(posedge clk);
		miscompares++;
		end_of_test();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		clk = 1'h0;
		rst = 1'h1;
		req = '0;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		for (int a = 0; a < 16; a++) begin
			if (a != 9) begin
				rd(a[3:0], got);
				chk("reset read", (a == 4) ? 16'h0002 : 16'h0000, got);
			end
		end
		chk("irq after reset", 16'h0000, {13'h0, irq_cond, irq_tx, irq_rx});
		b = $random(seed);
		wr(`UI2C_A_BRG, b);
		rd(`UI2C_A_BRG, got);
		chk("divider", {8'h00, b}, got);
		wr(4'hd, b);
		rd(4'hd, got);
		chk("unmapped", 16'h0000, got);
		$display("test registers done");
		wr(`UI2C_A_MODE, 8'h0a);
		wr(`UI2C_A_SMR, 8'h01);
		wr(`UI2C_A_CTL1, 8'h05);
		wr(`UI2C_A_IRQ, 8'h07);
		tick(2);
		chk("idle pins", 16'h0000, {14'h0, pins.scl_oe, pins.sda_oe});
		PARTNER.start_c();
		exp_start++;
		#1;
		chk("start irq", 16'h0001, {15'h0, irq_cond});
		rd(`UI2C_A_SMR, got);
		chk("busy after start", 16'h0004, got & 16'h0004);
		for (int k = 0; k < 5; k++) begin
			b = $random(seed);
			m2 = smr2_tab[k][0];
			wr(`UI2C_A_SMR2, smr2_tab[k]);
			wr(`UI2C_A_SMR4, smr4_tab[k]);
			wr(`UI2C_A_RXBUF, 8'h00);
			wr(`UI2C_A_TXBUF, 8'hff);
			wr(`UI2C_A_IRQ, 8'h07);
			rd(`UI2C_A_CTL1, got);
			chk("transmit empty", 16'h0002, got & 16'h0002);
			fork
				PARTNER.send_byte(b, mlow_tab[k]);
				begin
					@(posedge in_ack);
					tick(6);
					chk("ninth rise irq", {14'h0, m2 | nine_tab[k], ~(m2 | nine_tab[k])},
						{14'h0, irq_tx, irq_rx});
				end
			join
			tick(8);
			chk("ack slot level", {15'h0, nine_tab[k]}, {15'h0, ack_seen});
			rd(`UI2C_A_RXBUF, got);
			chk("receive buffer", rx_model(m2, nine_tab[k], b) & (m2 ? 16'h017f : 16'h01ff),
				got & (m2 ? 16'h017f : 16'h01ff));
			if (m2)
				chk("receive irq at fall", 16'h0001, {15'h0, irq_rx});
		end
		PARTNER.stop_c();
		exp_stop++;
		#1;
		chk("stop irq", 16'h0001, {15'h0, irq_cond});
		rd(`UI2C_A_SMR, got);
		chk("busy after stop", 16'h0000, got & 16'h0004);
		$display("test slave done");
		wr(`UI2C_A_CTL1, 8'h00);
		wr(`UI2C_A_MODE, 8'h02);
		wr(`UI2C_A_CTL0, 8'h00);
		wr(`UI2C_A_BRG, 8'h01);
		wr(`UI2C_A_SMR2, 8'h00);
		wr(`UI2C_A_IRQ, 8'h07);
		wr(`UI2C_A_SMR4, 8'h01);
		tick(20);
		chk("no condition before select", 16'h0000, {14'h0, pins.scl_oe, pins.sda_oe});
		for (int k = 0; k < 3; k++) begin
			wr(`UI2C_A_IRQ, 8'h07);
			wr(`UI2C_A_SMR4, cond_tab[k]);
			wait_cond();
			exp_start += (k < 2);
			exp_stop += (k == 2);
			chk("condition irq", 16'h0001, {15'h0, irq_cond});
			chk("starts on wire", 16'(exp_start), 16'(n_start));
			chk("stops on wire", 16'(exp_stop), 16'(n_stop));
			rd(`UI2C_A_SMR4, got);
			chk("request cleared", 16'h0000, got & 16'h0007);
			rd(`UI2C_A_SMR, got);
			chk("busy flag", (k < 2) ? 16'h0004 : 16'h0000, got & 16'h0004);
		end
		$display("test master conditions done");
		end_of_test();
	end
endmodule // ui2c_engine_test
